// file: core/scf_flash.sv
/*
  serial configuration flash, device side: samples the host's serial clock, select and command
  lines, holds a byte array, streams read data through a prefetch fifo.
  assumes the host is master and supplies the clock, much slower than sys_clk_i.
*/
`timescale 1ns/1ps
module scf_flash
   import scf_pkg::*;
#(
   parameter int DEPTH      = 256,
   parameter int FIFO_DEPTH = 32
) (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // serial link pins
   input  wire logic serial_clock_i,
   input  wire logic flash_select_n_i,
   input  wire logic flash_command_in_i,
   output logic      flash_data_o,
   output logic      flash_data_oe_o,
   // status
   output logic      flash_ready_o
);
   localparam int AW = $clog2(DEPTH);

   // the pins come from another domain; serial_clock_i is sampled, never used as a clock
   logic [2:0]  clk_sy_reg, cs_sy_reg, din_sy_reg;
   logic        clk_lvl_reg, cs_lvl_reg;
   logic [7:0]  mem [DEPTH];

   scf_state_t  state_reg, state_next;
   logic [7:0]  op_reg, op_next;
   logic [7:0]  in_sh_reg, in_sh_next;
   logic [2:0]  in_cnt_reg, in_cnt_next;
   logic [1:0]  abyte_reg, abyte_next;
   logic [SCF_ADDR_BITS-1:0] addr_reg, addr_next;
   logic [AW-1:0] fill_reg, fill_next;
   logic [7:0]  out_sh_reg, out_sh_next;
   logic [2:0]  out_cnt_reg, out_cnt_next;
   logic        data_reg, data_next;
   logic        oe_reg, oe_next;
   logic        wel_reg, wel_next;
   logic [2:0]  bp_reg, bp_next;
   logic        wipe_reg;
   logic [AW-1:0] wipe_addr_reg;
   logic        ready_reg;

   logic        flush, pop, mem_we;
   logic        fifo_in_ready, fifo_out_valid;
   logic [7:0]  fifo_out_data;
   logic [7:0]  status_w;
   logic [7:0]  load_byte;

   // a level counts only once the second and third stages agree
   wire clk_rise  = clk_sy_reg[1] && clk_sy_reg[2] && !clk_lvl_reg;
   wire clk_fall  = !clk_sy_reg[1] && !clk_sy_reg[2] && clk_lvl_reg;
   wire cs_rise   = cs_sy_reg[1] && cs_sy_reg[2] && !cs_lvl_reg;
   wire cs_fall   = !cs_sy_reg[1] && !cs_sy_reg[2] && cs_lvl_reg;
   wire selected  = !cs_lvl_reg;
   wire [7:0] byte_in   = {in_sh_reg[6:0], din_sy_reg[2]};
   wire       byte_done = clk_rise && selected && (in_cnt_reg == 3'h7);
   wire [SCF_ADDR_BITS-1:0] addr_full = {addr_reg[SCF_ADDR_BITS-9:0], byte_in};
   wire       is_read   = (state_reg == SCF_ST_READ);
   wire       shifting  = clk_fall && (is_read || state_reg == SCF_ST_RDSR);
   wire       fill_en   = is_read && !wipe_reg;

   // upper part of the array is locked, growing with the protect field
   function automatic logic is_protected(input logic [AW-1:0] a, input logic [2:0] bp);
      int lim;
      lim = DEPTH - (DEPTH >> (int'(SCF_BP_ALL) - int'(bp)));
      return (bp != SCF_BP_RESET) && (int'(a) >= lim);
   endfunction

   always_comb begin
      status_w = SCF_SR_RESET;
      status_w[SCF_SR_BP_LSB +: SCF_SR_BP_W] = bp_reg;
      status_w[SCF_SR_WEL_BIT] = wel_reg;
   end

   assign load_byte = is_read ? (fifo_out_valid ? fifo_out_data : SCF_ERASED) : status_w;

   always_comb begin
      state_next   = state_reg;
      op_next      = op_reg;
      in_sh_next   = in_sh_reg;
      in_cnt_next  = in_cnt_reg;
      abyte_next   = abyte_reg;
      addr_next    = addr_reg;
      fill_next    = fill_reg;
      out_sh_next  = out_sh_reg;
      out_cnt_next = out_cnt_reg;
      data_next    = data_reg;
      oe_next      = oe_reg;
      wel_next     = wel_reg;
      bp_next      = bp_reg;
      flush        = 1'b0;
      pop          = 1'b0;
      mem_we       = 1'b0;
      if (cs_rise || wipe_reg || !selected) begin
         // deselect ends the transaction and floats the data line
         state_next = SCF_ST_IDLE;
         oe_next    = 1'b0;
         data_next  = 1'b0;
         flush      = 1'b1;
         if (state_reg == SCF_ST_PROG) begin
            wel_next = 1'b0;
         end
         if (cs_fall && !wipe_reg) begin
            // select must precede the instruction
            state_next   = SCF_ST_CMD;
            in_cnt_next  = 3'h0;
            out_cnt_next = 3'h0;
            abyte_next   = 2'h0;
         end
      end else begin
         if (clk_rise) begin
            in_sh_next  = byte_in;
            in_cnt_next = 3'(in_cnt_reg + 3'h1);
         end
         case (state_reg)
            SCF_ST_CMD: begin
               if (byte_done) begin
                  op_next = byte_in;
                  case (byte_in)
                     SCF_OP_READ, SCF_OP_PROG: state_next = SCF_ST_ADDR;
                     SCF_OP_RDSR: state_next = SCF_ST_RDSR;
                     SCF_OP_WRSR: state_next = wel_reg ? SCF_ST_WRSR : SCF_ST_SKIP;
                     SCF_OP_WREN: begin
                        wel_next   = 1'b1;
                        state_next = SCF_ST_SKIP;
                     end
                     SCF_OP_WRDI: begin
                        wel_next   = 1'b0;
                        state_next = SCF_ST_SKIP;
                     end
                     default: state_next = SCF_ST_SKIP;
                  endcase
               end
            end
            SCF_ST_ADDR: begin
               if (byte_done) begin
                  addr_next  = addr_full;
                  abyte_next = 2'(abyte_reg + 2'h1);
                  if (abyte_reg == SCF_ADDR_LAST) begin
                     fill_next = addr_full[AW-1:0];
                     if (op_reg == SCF_OP_READ) begin
                        state_next = SCF_ST_READ;
                     end else begin
                        state_next = wel_reg ? SCF_ST_PROG : SCF_ST_SKIP;
                     end
                  end
               end
            end
            SCF_ST_READ: begin
               // prefetch runs ahead of the link and stalls when the fifo is full
               if (fifo_in_ready) begin
                  fill_next = AW'(fill_reg + 1'b1);
               end
            end
            SCF_ST_WRSR: begin
               if (byte_done) begin
                  bp_next    = byte_in[SCF_SR_BP_LSB +: SCF_SR_BP_W];
                  wel_next   = 1'b0;
                  state_next = SCF_ST_SKIP;
               end
            end
            SCF_ST_PROG: begin
               if (byte_done) begin
                  mem_we    = !is_protected(addr_reg[AW-1:0], bp_reg);
                  addr_next = SCF_ADDR_BITS'(addr_reg + 1'b1);
               end
            end
            default: ;
         endcase
         if (shifting) begin
            // new bit appears on each falling edge; host takes it one fall later
            oe_next = 1'b1;
            if (out_cnt_reg == 3'h0) begin
               data_next    = load_byte[7];
               out_sh_next  = {load_byte[6:0], 1'b0};
               out_cnt_next = 3'h7;
               pop          = is_read;
            end else begin
               data_next    = out_sh_reg[7];
               out_sh_next  = {out_sh_reg[6:0], 1'b0};
               out_cnt_next = 3'(out_cnt_reg - 3'h1);
            end
         end
      end
   end

   scf_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (sys_clk_i),
      .rst_i       (rst_i),
      .flush_i     (flush),
      .in_valid_i  (fill_en),
      .in_data_i   (mem[fill_reg]),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (fifo_out_valid),
      .out_data_o  (fifo_out_data),
      .out_ready_i (pop)
   );

   // programming only clears bits; the wipe after reset restores the erased array
   always_ff @(posedge sys_clk_i) begin
      if (wipe_reg) begin
         mem[wipe_addr_reg] <= SCF_ERASED;
      end else if (mem_we) begin
         mem[addr_reg[AW-1:0]] <= mem[addr_reg[AW-1:0]] & byte_in;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      clk_sy_reg <= {clk_sy_reg[1:0], serial_clock_i};
      cs_sy_reg  <= {cs_sy_reg[1:0], flash_select_n_i};
      din_sy_reg <= {din_sy_reg[1:0], flash_command_in_i};
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         clk_lvl_reg   <= 1'b0;
         cs_lvl_reg    <= 1'b1;
         wipe_reg      <= 1'b1;
         wipe_addr_reg <= '0;
         ready_reg     <= 1'b0;
      end else begin
         clk_lvl_reg   <= (clk_sy_reg[1] == clk_sy_reg[2]) ? clk_sy_reg[2] : clk_lvl_reg;
         cs_lvl_reg    <= (cs_sy_reg[1] == cs_sy_reg[2]) ? cs_sy_reg[2] : cs_lvl_reg;
         wipe_addr_reg <= AW'(wipe_addr_reg + 1'b1);
         wipe_reg      <= wipe_reg && (wipe_addr_reg != AW'(DEPTH - 1));
         ready_reg     <= !wipe_reg;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg   <= SCF_ST_IDLE;
         op_reg      <= 8'h00;
         in_sh_reg   <= 8'h00;
         in_cnt_reg  <= 3'h0;
         abyte_reg   <= 2'h0;
         addr_reg    <= '0;
         fill_reg    <= '0;
         out_sh_reg  <= 8'h00;
         out_cnt_reg <= 3'h0;
         data_reg    <= 1'b0;
         oe_reg      <= 1'b0;
         wel_reg     <= 1'b0;
         bp_reg      <= SCF_BP_RESET;
      end else begin
         state_reg   <= state_next;
         op_reg      <= op_next;
         in_sh_reg   <= in_sh_next;
         in_cnt_reg  <= in_cnt_next;
         abyte_reg   <= abyte_next;
         addr_reg    <= addr_next;
         fill_reg    <= fill_next;
         out_sh_reg  <= out_sh_next;
         out_cnt_reg <= out_cnt_next;
         data_reg    <= data_next;
         oe_reg      <= oe_next;
         wel_reg     <= wel_next;
         bp_reg      <= bp_next;
      end
   end

   assign flash_data_o    = data_reg;
   assign flash_data_oe_o = oe_reg;
   assign flash_ready_o   = ready_reg;

endmodule

// file: core/scf_pkg.sv
/*
  constants shared by the serial configuration flash model: opcodes, status register layout,
  address framing and reset values.
  assumes a mode-0 serial link (command sampled on rising, data launched on falling edges).
*/
package scf_pkg;

   // instruction opcodes
   localparam logic [7:0] SCF_OP_WRSR = 8'h01;
   localparam logic [7:0] SCF_OP_PROG = 8'h02;
   localparam logic [7:0] SCF_OP_READ = 8'h03;
   localparam logic [7:0] SCF_OP_WRDI = 8'h04;
   localparam logic [7:0] SCF_OP_RDSR = 8'h05;
   localparam logic [7:0] SCF_OP_WREN = 8'h06;

   // status register layout
   localparam int         SCF_SR_WEL_BIT = 1;
   localparam int         SCF_SR_BP_LSB  = 2;
   localparam int         SCF_SR_BP_W    = 3;
   localparam logic [7:0] SCF_SR_RESET   = 8'h00;
   localparam logic [2:0] SCF_BP_RESET   = 3'h0;
   localparam logic [2:0] SCF_BP_ALL     = 3'h7;

   // address framing and array contents
   localparam int         SCF_ADDR_BITS  = 24;
   localparam logic [1:0] SCF_ADDR_LAST  = 2'h2;
   localparam logic [7:0] SCF_ERASED     = 8'hFF;

   typedef enum logic [7:0] {
      SCF_ST_IDLE = 8'h01,
      SCF_ST_CMD  = 8'h02,
      SCF_ST_ADDR = 8'h04,
      SCF_ST_READ = 8'h08,
      SCF_ST_RDSR = 8'h10,
      SCF_ST_WRSR = 8'h20,
      SCF_ST_PROG = 8'h40,
      SCF_ST_SKIP = 8'h80
   } scf_state_t;

endpackage

// file: core/scf_fifo.sv
/*
  synchronous fifo with valid/ready on both sides and a flush.
  assumes one clock; flush wins over push and pop in the same cycle.
*/
`timescale 1ns/1ps
module scf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock, reset and flush
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   // fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // drain side
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr_reg;
   logic [PW:0]      rd_ptr_reg;
   wire              full_w  = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                               (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
   wire              empty_w = (wr_ptr_reg == rd_ptr_reg);
   wire              push_w  = in_valid_i && !full_w;
   wire              pop_w   = out_ready_i && !empty_w;

   assign in_ready_o  = !full_w;
   assign out_valid_o = !empty_w;
   assign out_data_o  = mem[rd_ptr_reg[PW-1:0]];

   always_ff @(posedge clk_i) begin
      if (push_w) begin
         mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= push_w ? (PW+1)'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
         rd_ptr_reg <= pop_w ? (PW+1)'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      end
   end

endmodule

// file: dv/scf_flash_properties.sv
/*
  concurrent checks on the flash pins, bound into scf_flash.
  assumes a link clock far slower than sys_clk_i, as in the bench.
*/
`timescale 1ns/1ps
module scf_flash_properties #(
   parameter int DEPTH = 256
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // link pins
   input wire logic serial_clock_i,
   input wire logic flash_select_n_i,
   input wire logic flash_command_in_i,
   input wire logic flash_data_o,
   input wire logic flash_data_oe_o,
   // status
   input wire logic flash_ready_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff rst_i;

   // cycles since reset release, frozen at zero once ready
   logic [15:0] wipe_reg;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || flash_ready_o)
         wipe_reg <= 16'h0000;
      else
         wipe_reg <= wipe_reg + 16'h0001;
   end

   idle_oe_a: assert property (flash_select_n_i [*7] |-> !flash_data_oe_o)
      else $error("data line driven while deselected");
   idle_low_a: assert property (flash_select_n_i [*7] |-> !flash_data_o)
      else $error("data not at idle level while deselected");
   sel_first_a: assert property (flash_data_oe_o |-> !$past(flash_select_n_i, 5))
      else $error("data driven without select");
   // 3-flop sampling puts each launch 3 to 4 cycles after the pin fall
   fall_launch_a: assert property (flash_data_oe_o && $past(flash_data_oe_o) &&
      $changed(flash_data_o) |-> !$past(serial_clock_i, 3) && $past(serial_clock_i, 6))
      else $error("data bit not launched on a falling edge");
   oe_start_a: assert property ($rose(flash_data_oe_o) |->
      !$past(serial_clock_i, 3) && !$past(flash_select_n_i, 3))
      else $error("drive started off a falling edge");
   ready_early_a: assert property ($rose(flash_ready_o) |-> wipe_reg >= DEPTH)
      else $error("ready before erase wipe finished");
   ready_late_a: assert property (!flash_ready_o |-> wipe_reg <= DEPTH + 8)
      else $error("ready late after erase wipe");
   rst_quiet_a: assert property ($fell(rst_i) |-> !flash_data_oe_o && !flash_ready_o)
      else $error("outputs active right after reset");

   read_seen_c: cover property ($rose(flash_data_oe_o));
   wipe_done_c: cover property ($rose(flash_ready_o));
   end_frame_c: cover property ($fell(flash_data_oe_o));
endmodule

bind scf_flash scf_flash_properties #(.DEPTH(DEPTH)) props (
   .sys_clk_i          (sys_clk_i),
   .rst_i              (rst_i),
   .serial_clock_i     (serial_clock_i),
   .flash_select_n_i   (flash_select_n_i),
   .flash_command_in_i (flash_command_in_i),
   .flash_data_o       (flash_data_o),
   .flash_data_oe_o    (flash_data_oe_o),
   .flash_ready_o      (flash_ready_o)
);

// file: dv/scf_host_model.sv
/*
  host side of the link: master that clocks, selects and shifts frames into the flash.
  assumes the bench calls run at a falling sys_clk_i edge; pins move on falling edges.
*/
`timescale 1ns/1ps
module scf_host_model
   import scf_pkg::*;
(
   // clock
   input  wire logic sys_clk_i,
   // link pins
   output logic      serial_clock_o,
   output logic      select_n_o,
   output logic      command_o,
   input  wire logic data_i
);
   logic [15:0] rx;
   // done, restart and user mode of the single master; the flash is never cascaded
   logic        config_complete;
   logic        config_fault_restart_n;
   logic        user_mode;
   int          restarts;

   initial begin
      serial_clock_o         = 1'b0;
      select_n_o             = 1'b1;
      command_o              = 1'b0;
      rx                     = 16'h0000;
      config_complete        = 1'b0;
      config_fault_restart_n = 1'b1;
      user_mode              = 1'b0;
      restarts               = 0;
   end

   task automatic half();
      repeat (4) @(negedge sys_clk_i);
   endtask

   // link clock stands low between frames, 160 ns period inside them
   task automatic run(input logic [39:0] tx, input int nbits, input int nrx);
      rx = 16'h0000;
      select_n_o = 1'b0;
      half();
      for (int i = 0; i < nbits; i++) begin
         command_o = tx[39-i];
         half();
         serial_clock_o = 1'b1;
         half();
         serial_clock_o = 1'b0;
      end
      command_o = 1'b0;
      for (int i = 0; i < 8 * nrx; i++) begin
         half();
         serial_clock_o = 1'b1;
         half();
         rx = {rx[14:0], data_i};
         serial_clock_o = 1'b0;
      end
      half();
      select_n_o = 1'b1;
      half();
   endtask

   // a blank image never raises done, so restart is pulsed and the load retried
   task automatic boot(input logic [39:0] tx, input int tries);
      restarts  = 0;
      user_mode = 1'b0;
      for (int t = 0; t < tries && !user_mode; t++) begin
         config_complete = 1'b0;
         run(tx, 32, 2);
         if (rx[15:8] == SCF_ERASED) begin
            config_fault_restart_n = 1'b0;
            half();
            config_fault_restart_n = 1'b1;
            restarts++;
         end else begin
            config_complete = 1'b1;
            half();
            user_mode = config_complete;
         end
      end
   endtask
endmodule

// file: dv/scf_flash_tb_top.sv
/*
  self-checking bench for scf_flash with a host model on the link.
  assumes DEPTH 16 to keep the erase wipe short.
*/
`timescale 1ns/1ps
module scf_flash_tb_top;
   import scf_pkg::*;
   typedef struct {
      logic [39:0] tx;
      int          nbits;
      int          nrx;
      logic [15:0] exp;
   } scf_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tgl = 1'b0;
   logic sclk;
   logic sel_n;
   logic cmd;
   logic dout;
   logic oe;
   logic rdy;
   logic sd;
   int   fails = 0;
   int   comparisons = 0;
   scf_row_t rows [16] = '{
      '{{SCF_OP_READ, 32'h0000_0000}, 32, 2, 16'hFFFF},
      '{{SCF_OP_READ, 32'h0000_0F00}, 32, 2, 16'hFFFF},
      '{{SCF_OP_RDSR, 32'h0}, 8, 2, {2{SCF_SR_RESET}}},
      '{{SCF_OP_PROG, 32'h0000_0500}, 40, 0, 16'h0000},
      '{{SCF_OP_READ, 32'h0000_0500}, 32, 2, 16'hFFFF},
      '{{SCF_OP_WREN, 32'h0}, 8, 0, 16'h0000},
      '{{SCF_OP_RDSR, 32'h0}, 8, 2, 16'h0202},
      '{{SCF_OP_PROG, 32'h0000_03A5}, 40, 0, 16'h0000},
      '{{SCF_OP_READ, 32'h0000_0300}, 32, 2, 16'hA5FF},
      '{{SCF_OP_RDSR, 32'h0}, 8, 2, 16'h0000},
      '{{SCF_OP_WREN, 32'h0}, 8, 0, 16'h0000},
      '{{SCF_OP_WRSR, 32'h1C00_0000}, 16, 0, 16'h0000},
      '{{SCF_OP_RDSR, 32'h0}, 8, 2, 16'h1C1C},
      '{{SCF_OP_WREN, 32'h0}, 8, 0, 16'h0000},
      '{{SCF_OP_PROG, 32'h0000_0400}, 40, 0, 16'h0000},
      '{{SCF_OP_READ, 32'h0000_0400}, 32, 2, 16'hFFFF}
   };

   always #10 clk = ~clk;
   // a released line shows a moving pattern, never a stale bit
   always @(posedge clk) tgl <= ~tgl;
   assign sd = oe ? dout : tgl;

   scf_flash #(.DEPTH(16), .FIFO_DEPTH(32)) dut (
      .sys_clk_i          (clk),
      .rst_i              (rst),
      .serial_clock_i     (sclk),
      .flash_select_n_i   (sel_n),
      .flash_command_in_i (cmd),
      .flash_data_o       (dout),
      .flash_data_oe_o    (oe),
      .flash_ready_o      (rdy)
   );
   scf_host_model host (
      .sys_clk_i      (clk),
      .serial_clock_o (sclk),
      .select_n_o     (sel_n),
      .command_o      (cmd),
      .data_i         (sd)
   );

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic do_reset();
      int n;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      check("pins in reset", {13'h0, oe, dout, rdy}, 16'h0000);
      rst = 1'b0;
      n = 0;
      while (rdy !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      check("ready", {15'h0, rdy}, 16'h0001);
   endtask

   initial begin
      do_reset();
      foreach (rows[i]) begin
         host.run(rows[i].tx, rows[i].nbits, rows[i].nrx);
         if (rows[i].nrx > 0)
            check($sformatf("row %0d", i), host.rx, rows[i].exp);
      end
      // partial frame is dropped and must not disturb the next one
      host.run({SCF_OP_READ, 32'h0000_0300}, 12, 0);
      host.run({SCF_OP_READ, 32'h0000_0300}, 32, 2);
      check("after abort", host.rx, 16'hA5FF);
      host.boot({SCF_OP_READ, 32'h0000_0300}, 2);
      check("boot ok", {14'h0, host.user_mode, host.config_complete}, 16'h0003);
      check("no restart", 16'(host.restarts), 16'h0000);
      do_reset();
      host.run({SCF_OP_READ, 32'h0000_0300}, 32, 2);
      check("wiped again", host.rx, 16'hFFFF);
      host.boot({SCF_OP_READ, 32'h0000_0000}, 2);
      check("blank boot", {14'h0, host.user_mode, host.config_complete}, 16'h0000);
      check("restarts", 16'(host.restarts), 16'h0002);
      repeat (4) @(negedge clk);
      check("idle line", {14'h0, oe, dout}, 16'h0000);
      test_done();
   end

   initial begin
      #1000000;
      fails++;
      test_done();
   end
endmodule
